/* src/ecl_regs.svh */
// Offsets, field positions and fixed values of the configuration image loader
`ifndef ECL_REGS_SVH
`define ECL_REGS_SVH

// ****************************************
// Image layout (byte locations)
// ****************************************
`define ECL_SIG_LOC       6'h00
`define ECL_SIG_VALUE     8'ha5
`define ECL_STA_FIRST     6'h01
`define ECL_FS_POLL_LOC   6'h07
`define ECL_HS_POLL_LOC   6'h08
`define ECL_FLAGS_LOC     6'h09
`define ECL_LANG_LO_LOC   6'h0a
`define ECL_LANG_HI_LOC   6'h0b
`define ECL_ITEM_BASE     6'h0c
`define ECL_WAKE_LO_LOC   6'h1e
`define ECL_WAKE_HI_LOC   6'h1f
`define ECL_PM_FLAGS_LOC  6'h20
`define ECL_HDR_LAST      6'h20
`define ECL_HDR_BYTES     33

// ****************************************
// Length/pointer items
// ****************************************
`define ECL_NUM_ITEMS     4'd9
`define ECL_NUM_STRINGS   4'd5
`define ECL_ITEM_HS_DEV   4'd5
`define ECL_ITEM_HS_CFG   4'd6
`define ECL_ITEM_FS_DEV   4'd7
`define ECL_ITEM_FS_CFG   4'd8

// ****************************************
// Flag bits and descriptor overrides
// ****************************************
`define ECL_FLAG_SELF     0
`define ECL_FLAG_LED      1
`define ECL_FLAG_RWAKE    2
`define ECL_DSC_LEN_OFS   8'h00
`define ECL_DSC_TYPE_OFS  8'h01
`define ECL_DEV_SIZE      8'h12
`define ECL_DEV_TYPE      8'h01
`define ECL_CFG_TYPE      8'h02
`define ECL_CFG_ATTR_OFS  8'h07
`define ECL_ATTR_RWAKE    5
`define ECL_ATTR_SELF     6

// ****************************************
// APB register byte offsets
// ****************************************
`define ECL_REG_STATUS    12'h000
`define ECL_REG_CTRL      12'h004
`define ECL_REG_ADDR_LO   12'h008
`define ECL_REG_ADDR_HI   12'h00c
`define ECL_REG_POLL      12'h010
`define ECL_REG_GPIO      12'h014
`define ECL_CTRL_RELOAD   0

`endif

/* src/ecl_pkg.sv */
// Types shared by the configuration image loader
package ecl_pkg;

    // ****************************************
    // Loader states
    // ****************************************
    typedef enum logic [2:0] {
        ST_START,
        ST_SIG,
        ST_HDR,
        ST_PICK,
        ST_DESC,
        ST_FINISH,
        ST_DONE
    } ecl_state_t;

    // ****************************************
    // Image byte read request
    // ****************************************
    typedef struct packed {
        logic       req;
        logic [8:0] addr;
    } ecl_rd_req_t;

    // ****************************************
    // Descriptor byte stream
    // ****************************************
    typedef struct packed {
        logic       valid;
        logic [3:0] item;
        logic [7:0] offset;
        logic [7:0] data;
    } ecl_desc_t;

    // ****************************************
    // Loaded device settings
    // ****************************************
    typedef struct packed {
        logic [7:0]  fs_poll;
        logic [7:0]  hs_poll;
        logic [15:0] lang_id;
        logic        lang_valid;
        logic [10:0] pin_wake_enable_bits;
        logic [7:0]  pm_flags;
        logic        remote_wakeup;
        logic        led_function_select;
        logic        self_powered;
        logic [8:0]  item_present;
    } ecl_cfg_t;

endpackage

/* src/ecl_loader.sv */
// Configuration image loader with APB status and control registers
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "ecl_regs.svh"

module ecl_loader
    import ecl_pkg::*;
#(
    parameter logic [47:0] STATION_DEFAULT = 48'h0000_0000_0000,
    parameter logic [7:0]  FS_POLL_DEFAULT = 8'h01,
    parameter logic [7:0]  HS_POLL_DEFAULT = 8'h04,
    parameter logic [15:0] LANG_DEFAULT    = 16'h0409,
    parameter logic        LED_DEFAULT     = 1'b0,
    parameter logic        SELF_DEFAULT    = 1'b0
) (
    input  wire logic        pclk,                // System clock
    input  wire logic        presetn,             // Asynchronous reset, active low
    input  wire logic        psel,                // APB select
    input  wire logic        penable,             // APB enable
    input  wire logic        pwrite,              // APB write
    input  wire logic [11:0] paddr,               // APB byte address
    input  wire logic [31:0] pwdata,              // APB write data
    output logic      [31:0] prdata,              // APB read data
    output logic             pready,              // APB ready
    output logic             pslverr,             // APB error
    output ecl_rd_req_t      ee_rd,               // Image byte read request
    input  wire logic        ee_ack,              // Read data valid pulse
    input  wire logic [7:0]  ee_data,             // Read data byte
    input  wire logic        remote_wakeup_strap, // Remote wakeup strap level
    output ecl_desc_t        desc,                // Descriptor byte stream
    output ecl_cfg_t         cfg,                 // Loaded device settings
    output logic [15:0]      station_addr_high,   // MAC address bits 47:32
    output logic [31:0]      station_addr_low,    // MAC address bits 31:0
    output logic             station_addr_wr,     // MAC address load pulse
    output logic             usb_accept           // USB transactions accepted
);

    // ****************************************
    // Declarations
    // ****************************************
    ecl_state_t  state_ff;
    ecl_rd_req_t rd_ff;
    ecl_desc_t   desc_ff;
    ecl_cfg_t    cfg_ff;
    logic [7:0]  hdr_ff [`ECL_HDR_BYTES];
    logic [5:0]  hdr_idx_ff;
    logic [3:0]  item_ff;
    logic [7:0]  ofs_ff;
    logic        sig_ok_ff;
    logic        strap_ff;
    logic        dcfg_seen_ff;
    logic        dcfg_rwake_ff;
    logic        dcfg_self_ff;
    logic [47:0] sta_ff;
    logic        sta_wr_ff;
    logic        accept_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        setup;
    logic        reload;
    logic [7:0]  cur_len;
    logic [8:0]  cur_addr;
    logic [7:0]  nxt_desc_byte;
    logic        any_string;

    // ****************************************
    // Functions
    // ****************************************
    // Length byte of an item
    function automatic logic [7:0] item_len(input logic [3:0] k);
        logic [5:0] loc;
        loc = 6'(`ECL_ITEM_BASE + {k, 1'b0});
        return hdr_ff[loc];
    endfunction

    // Word pointer byte of an item
    function automatic logic [7:0] item_ptr(input logic [3:0] k);
        logic [5:0] loc;
        loc = 6'(`ECL_ITEM_BASE + {k, 1'b0} + 6'h01);
        return hdr_ff[loc];
    endfunction

    // Device descriptor items
    function automatic logic is_dev(input logic [3:0] k);
        return (k == `ECL_ITEM_HS_DEV) || (k == `ECL_ITEM_FS_DEV);
    endfunction

    // Configuration descriptor items
    function automatic logic is_cfg(input logic [3:0] k);
        return (k == `ECL_ITEM_HS_CFG) || (k == `ECL_ITEM_FS_CFG);
    endfunction

    // ****************************************
    // Combinational helpers
    // ****************************************
    // Byte address of the current descriptor byte
    always_comb begin
        cur_len  = item_len(item_ff);
        cur_addr = 9'({item_ptr(item_ff), 1'b0} + {1'b0, ofs_ff});
    end

    // Fixed descriptor fields replace image content
    always_comb begin
        nxt_desc_byte = ee_data;
        if (is_dev(item_ff) && ofs_ff == `ECL_DSC_LEN_OFS) begin
            nxt_desc_byte = `ECL_DEV_SIZE;
        end else if (is_dev(item_ff) && ofs_ff == `ECL_DSC_TYPE_OFS) begin
            nxt_desc_byte = `ECL_DEV_TYPE;
        end else if (is_cfg(item_ff) && ofs_ff == `ECL_DSC_TYPE_OFS) begin
            nxt_desc_byte = `ECL_CFG_TYPE;
        end
    end

    // Any string descriptor present
    always_comb begin
        any_string = 1'b0;
        for (int k = 0; k < 5; k++) begin
            any_string = any_string | (item_len(4'(k)) != 8'h00);
        end
    end

    assign setup  = psel && !penable;
    // Reload takes effect at the access edge, when the master sees ready
    assign reload = psel && penable && pready_ff && pwrite && paddr == `ECL_REG_CTRL
                    && pwdata[`ECL_CTRL_RELOAD] && state_ff == ST_DONE;

    // ****************************************
    // Loader sequencer
    // ****************************************
    // Walks signature, header bytes, then each present item
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= ST_START;
            hdr_idx_ff <= 6'h00;
            item_ff    <= 4'h0;
            ofs_ff     <= 8'h00;
            sig_ok_ff  <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_START: begin
                    sig_ok_ff <= 1'b0;
                    state_ff  <= ST_SIG;
                end
                ST_SIG: if (ee_ack) begin
                    if (ee_data == `ECL_SIG_VALUE) begin
                        sig_ok_ff  <= 1'b1;
                        hdr_idx_ff <= `ECL_STA_FIRST;
                        state_ff   <= ST_HDR;
                    end else begin
                        state_ff <= ST_FINISH;
                    end
                end
                ST_HDR: if (ee_ack) begin
                    if (hdr_idx_ff == `ECL_HDR_LAST) begin
                        item_ff  <= 4'h0;
                        state_ff <= ST_PICK;
                    end else begin
                        hdr_idx_ff <= hdr_idx_ff + 6'h01;
                    end
                end
                ST_PICK: begin
                    if (item_ff == `ECL_NUM_ITEMS) begin
                        state_ff <= ST_FINISH;
                    end else if (cur_len != 8'h00) begin
                        ofs_ff   <= 8'h00;
                        state_ff <= ST_DESC;
                    end else begin
                        item_ff <= item_ff + 4'h1;
                    end
                end
                ST_DESC: if (ee_ack) begin
                    if (ofs_ff == cur_len - 8'h01) begin
                        item_ff  <= item_ff + 4'h1;
                        state_ff <= ST_PICK;
                    end else begin
                        ofs_ff <= ofs_ff + 8'h01;
                    end
                end
                ST_FINISH: state_ff <= ST_DONE;
                ST_DONE: if (reload) begin
                    state_ff <= ST_START;
                end
            endcase
        end
    end

    // Image read request, held until acknowledged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= '0;
        end else if (ee_ack) begin
            rd_ff.req <= 1'b0;
        end else if (!rd_ff.req) begin
            unique case (state_ff)
                ST_SIG: begin
                    rd_ff.req  <= 1'b1;
                    rd_ff.addr <= {3'h0, `ECL_SIG_LOC};
                end
                ST_HDR: begin
                    rd_ff.req  <= 1'b1;
                    rd_ff.addr <= {3'h0, hdr_idx_ff};
                end
                ST_DESC: begin
                    rd_ff.req  <= 1'b1;
                    rd_ff.addr <= cur_addr;
                end
                default: rd_ff.req <= 1'b0;
            endcase
        end
    end

    // Header byte store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `ECL_HDR_BYTES; i++) begin
                hdr_ff[i] <= 8'h00;
            end
        end else if (state_ff == ST_HDR && ee_ack) begin
            hdr_ff[hdr_idx_ff] <= ee_data;
        end
    end

    // Descriptor byte stream with fixed fields applied
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_ff <= '0;
        end else begin
            desc_ff.valid <= state_ff == ST_DESC && ee_ack;
            if (state_ff == ST_DESC && ee_ack) begin
                desc_ff.item   <= item_ff;
                desc_ff.offset <= ofs_ff;
                desc_ff.data   <= nxt_desc_byte;
            end
        end
    end

    // Power and wakeup bits from a stored configuration descriptor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dcfg_seen_ff  <= 1'b0;
            dcfg_rwake_ff <= 1'b0;
            dcfg_self_ff  <= 1'b0;
        end else if (state_ff == ST_START) begin
            dcfg_seen_ff <= 1'b0;
        end else if (state_ff == ST_DESC && ee_ack && is_cfg(item_ff) && !dcfg_seen_ff
                     && ofs_ff == `ECL_CFG_ATTR_OFS) begin
            dcfg_seen_ff  <= 1'b1;
            dcfg_rwake_ff <= ee_data[`ECL_ATTR_RWAKE];
            dcfg_self_ff  <= ee_data[`ECL_ATTR_SELF];
        end
    end

    // Strap caught at the start of each load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_ff <= 1'b0;
        end else if (state_ff == ST_START) begin
            strap_ff <= remote_wakeup_strap;
        end
    end

    // ****************************************
    // Settings latched at the end of a load
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff    <= '0;
            sta_ff    <= 48'h0;
            sta_wr_ff <= 1'b0;
            accept_ff <= 1'b0;
        end else begin
            sta_wr_ff <= 1'b0;
            if (state_ff == ST_START) begin
                accept_ff <= 1'b0;
            end else if (state_ff == ST_FINISH) begin
                accept_ff <= 1'b1;
                sta_wr_ff <= 1'b1;
                if (sig_ok_ff) begin
                    sta_ff <= {hdr_ff[6], hdr_ff[5], hdr_ff[4],
                               hdr_ff[3], hdr_ff[2], hdr_ff[1]};
                    cfg_ff.fs_poll    <= hdr_ff[`ECL_FS_POLL_LOC];
                    cfg_ff.hs_poll    <= hdr_ff[`ECL_HS_POLL_LOC];
                    cfg_ff.lang_id    <= {hdr_ff[`ECL_LANG_HI_LOC],
                                          hdr_ff[`ECL_LANG_LO_LOC]};
                    cfg_ff.lang_valid <= any_string;
                    cfg_ff.pin_wake_enable_bits <= {hdr_ff[`ECL_WAKE_HI_LOC][2:0],
                                                    hdr_ff[`ECL_WAKE_LO_LOC]};
                    cfg_ff.pm_flags   <= hdr_ff[`ECL_PM_FLAGS_LOC];
                    cfg_ff.led_function_select <= hdr_ff[`ECL_FLAGS_LOC][`ECL_FLAG_LED];
                    cfg_ff.remote_wakeup <= dcfg_seen_ff ? dcfg_rwake_ff
                        : hdr_ff[`ECL_FLAGS_LOC][`ECL_FLAG_RWAKE];
                    cfg_ff.self_powered  <= dcfg_seen_ff ? dcfg_self_ff
                        : hdr_ff[`ECL_FLAGS_LOC][`ECL_FLAG_SELF];
                    for (int k = 0; k < 9; k++) begin
                        cfg_ff.item_present[k] <= item_len(4'(k)) != 8'h00;
                    end
                end else begin
                    sta_ff <= STATION_DEFAULT;
                    cfg_ff.fs_poll    <= FS_POLL_DEFAULT;
                    cfg_ff.hs_poll    <= HS_POLL_DEFAULT;
                    cfg_ff.lang_id    <= LANG_DEFAULT;
                    cfg_ff.lang_valid <= 1'b0;
                    cfg_ff.pin_wake_enable_bits <= 11'h000;
                    cfg_ff.pm_flags   <= 8'h00;
                    cfg_ff.led_function_select <= LED_DEFAULT;
                    cfg_ff.remote_wakeup <= strap_ff;
                    cfg_ff.self_powered  <= SELF_DEFAULT;
                    cfg_ff.item_present  <= 9'h000;
                end
            end
        end
    end

    // ****************************************
    // APB slave, zero wait states
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= 1'b0;
            if (setup) begin
                prdata_ff <= 32'h0000_0000;
                unique case (paddr)
                    `ECL_REG_STATUS:  prdata_ff <= {28'h0, cfg_ff.lang_valid, sig_ok_ff,
                                                    state_ff != ST_DONE, accept_ff};
                    `ECL_REG_CTRL:    prdata_ff <= 32'h0000_0000;
                    `ECL_REG_ADDR_LO: prdata_ff <= sta_ff[31:0];
                    `ECL_REG_ADDR_HI: prdata_ff <= {16'h0, sta_ff[47:32]};
                    `ECL_REG_POLL:    prdata_ff <= {cfg_ff.lang_id, cfg_ff.hs_poll,
                                                    cfg_ff.fs_poll};
                    `ECL_REG_GPIO:    prdata_ff <= {5'h0, cfg_ff.remote_wakeup,
                                                    cfg_ff.led_function_select,
                                                    cfg_ff.self_powered, cfg_ff.pm_flags,
                                                    5'h0, cfg_ff.pin_wake_enable_bits};
                    default:          pslverr_ff <= 1'b1;
                endcase
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata            = prdata_ff;
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign ee_rd             = rd_ff;
    assign desc              = desc_ff;
    assign cfg               = cfg_ff;
    assign station_addr_high = sta_ff[47:32];
    assign station_addr_low  = sta_ff[31:0];
    assign station_addr_wr   = sta_wr_ff;
    assign usb_accept        = accept_ff;

endmodule

/* sim/ecl_loader_sva.sv */
// Port checks for the configuration image loader
`timescale 1ns/10ps
module ecl_loader_sva
    import ecl_pkg::*;
(
    input wire logic        pclk,            // Clock
    input wire logic        presetn,         // Reset, active low
    input wire logic        psel,            // APB select
    input wire logic        penable,         // APB enable
    input wire logic [11:0] paddr,           // APB address
    input wire logic        pready,          // APB ready
    input wire logic        pslverr,         // APB error
    input wire ecl_rd_req_t ee_rd,           // Byte read request
    input wire logic        ee_ack,          // Byte valid pulse
    input wire ecl_desc_t   desc,            // Descriptor bytes
    input wire logic        station_addr_wr, // Address load pulse
    input wire logic        usb_accept       // USB accepted
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****************************************
    // Bus, read link, descriptor overrides and load end
    // ****************************************
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence dev_s;
        desc.valid && (desc.item == 4'd5 || desc.item == 4'd7);
    endsequence
    sequence cfg_s;
        desc.valid && (desc.item == 4'd6 || desc.item == 4'd8);
    endsequence
    chk_apb_ready: assert property (setup_s |=> pready)
        else $error("ready missing after setup");
    chk_apb_unmapped: assert property (setup_s ##0 paddr > 12'h014 |=> pslverr)
        else $error("unmapped access not flagged");
    chk_req_holds: assert property (ee_rd.req && !ee_ack |=> ee_rd.req && $stable(ee_rd.addr))
        else $error("read request dropped early");
    chk_req_drops: assert property (ee_ack |=> !ee_rd.req)
        else $error("read request held after ack");
    chk_desc_follows: assert property (desc.valid |-> $past(ee_ack))
        else $error("descriptor byte without read");
    chk_dev_size: assert property (dev_s ##0 desc.offset == 8'h00 |-> desc.data == 8'h12)
        else $error("device size not forced");
    chk_dev_type: assert property (dev_s ##0 desc.offset == 8'h01 |-> desc.data == 8'h01)
        else $error("device type not forced");
    chk_cfg_type: assert property (cfg_s ##0 desc.offset == 8'h01 |-> desc.data == 8'h02)
        else $error("config type not forced");
    chk_no_read_done: assert property (usb_accept |-> !ee_rd.req)
        else $error("reading while accepting");
    chk_addr_load: assert property (station_addr_wr |-> $rose(usb_accept))
        else $error("address load off load end");
    chk_addr_pulse: assert property ($rose(usb_accept) |-> station_addr_wr)
        else $error("no address load at load end");
endmodule

/* sim/ecl_eeprom_model.sv */
// Serial image memory seen as a byte read link
`timescale 1ns/10ps
module ecl_eeprom_model
    import ecl_pkg::*;
(
    input  wire logic        pclk,    // Clock
    input  wire logic        presetn, // Reset, active low
    input  wire ecl_rd_req_t ee_rd,   // Byte read request
    output logic             ee_ack,  // Byte valid pulse
    output logic [7:0]       ee_data  // Byte value
);
    logic [7:0] mem [0:511];
    logic [1:0] wait_ff;
    // Answer at once on even bytes, three cycles late on odd
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ee_ack <= 1'b0;
            ee_data <= 8'h00;
            wait_ff <= 2'd0;
        end else if (ee_ack) begin
            ee_ack <= 1'b0;
            ee_data <= ~ee_data; // No stale byte once released
        end else if (ee_rd.req && wait_ff == (ee_rd.addr[0] ? 2'd3 : 2'd0)) begin
            ee_ack <= 1'b1;
            ee_data <= mem[ee_rd.addr];
            wait_ff <= 2'd0;
        end else begin
            wait_ff <= ee_rd.req ? wait_ff + 2'd1 : 2'd0;
            ee_data <= ~ee_data;
        end
    end
endmodule

/* sim/ecl_loader_tb.sv */
// Self-checking bench for the configuration image loader
`timescale 1ns/10ps
module ecl_loader_tb
    import ecl_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        strap = 1'b0, ee_ack, pready, pslverr, usb_accept, sa_wr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, sa_lo, rd;
    logic [15:0] sa_hi;
    logic [7:0]  ee_data;
    logic [7:0]  ptr [0:8];
    ecl_rd_req_t ee_rd;
    ecl_desc_t   desc;
    ecl_cfg_t    cfg;
    int          fails = 0, cmp_count = 0, reads = 0, dbytes = 0;
    ecl_loader dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ee_rd(ee_rd), .ee_ack(ee_ack), .ee_data(ee_data),
        .remote_wakeup_strap(strap), .desc(desc), .cfg(cfg), .station_addr_high(sa_hi),
        .station_addr_low(sa_lo), .station_addr_wr(sa_wr), .usb_accept(usb_accept));
    ecl_eeprom_model ee_u (.pclk(pclk), .presetn(presetn), .ee_rd(ee_rd), .ee_ack(ee_ack),
        .ee_data(ee_data));
    always #50 pclk = ~pclk;
    // Count reads and judge every streamed descriptor byte
    always @(negedge pclk) begin
        if (ee_ack === 1'b1) reads++;
        if (desc.valid === 1'b1) begin
            dbytes++;
            chk(desc.data, exp_desc(desc.item, desc.offset), "desc byte");
        end
    end
    function automatic logic [7:0] exp_desc(input logic [3:0] it, input logic [7:0] ofs);
        if ((it == 4'd5 || it == 4'd7) && ofs == 8'h00) return 8'h12;
        if ((it == 4'd5 || it == 4'd7) && ofs == 8'h01) return 8'h01;
        if ((it == 4'd6 || it == 4'd8) && ofs == 8'h01) return 8'h02;
        return ee_u.mem[{1'b0, ptr[it]} * 9'd2 + {1'b0, ofs}];
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer; the bus stays selected until idle or the next setup
    task automatic apb(input logic wr, input logic [11:0] a);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) fails++;
    endtask
    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic item(input int k, input logic [7:0] len, input logic [7:0] p);
        ee_u.mem[12 + 2 * k] = len;
        ee_u.mem[13 + 2 * k] = p;
        ptr[k] = p;
    endtask
    task automatic img(input logic [7:0] sig, input logic [7:0] flags);
        for (int i = 0; i < 512; i++) ee_u.mem[i] = 8'(i) ^ 8'h3c;
        for (int k = 0; k < 9; k++) item(k, 8'h00, 8'h00);
        ee_u.mem[0] = sig;
        ee_u.mem[9] = flags;
    endtask
    // Reset the loader, then wait for the load to end
    task automatic run(input int exp_reads);
        presetn <= 1'b0;
        reads = 0;
        dbytes = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(usb_accept, 1'b0, "accept while loading");
        wait_load(exp_reads);
    endtask
    // Wait for the load to end, then judge the read count
    task automatic wait_load(input int exp_reads);
        int n;
        n = 0;
        while (usb_accept !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) fails++;
        repeat (2) @(posedge pclk);
        chk(reads, exp_reads, "image reads");
    endtask
    task automatic t_full();
        img(8'ha5, 8'h03);
        item(0, 8'h04, 8'h20);
        item(5, 8'd18, 8'h30);
        item(8, 8'd18, 8'h40);
        ee_u.mem[9'h062] = 8'h00;
        ee_u.mem[9'h063] = 8'h02;
        ee_u.mem[9'h067] = 8'h40;
        ee_u.mem[9'h071] = 8'h01;
        ee_u.mem[9'h06f] = 8'h00;
        ee_u.mem[9'h070] = 8'h00;
        ee_u.mem[9'h087] = 8'h20;
        ee_u.mem[9'h01e] = 8'hff;
        ee_u.mem[9'h01f] = 8'hfd;
        ee_u.mem[9'h020] = 8'h5a;
        strap <= 1'b0;
        run(73);
        chk(dbytes, 40, "desc count");
        chk({sa_hi, sa_lo}, 48'h3a39_383f_3e3d, "station");
        chk({cfg.fs_poll, cfg.hs_poll, cfg.lang_id}, 32'h3b34_3736, "poll lang");
        chk({cfg.lang_valid, cfg.pin_wake_enable_bits, cfg.pm_flags}, 20'hdff5a, "wake");
        chk({cfg.remote_wakeup, cfg.led_function_select, cfg.self_powered}, 3'b110, "f");
        chk(cfg.item_present, 9'h121, "items");
        apb(1'b0, 12'h000);
        chk(rd, 32'hd, "status");
        apb(1'b0, 12'h010);
        chk(rd, 32'h3736_343b, "poll reg");
        apb(1'b0, 12'h100);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped");
        idle();
        $display("t_full done");
    endtask
    task automatic t_nostr();
        img(8'ha5, 8'h05);
        strap <= 1'b0;
        run(33);
        chk(dbytes, 0, "desc count");
        chk({cfg.lang_valid, cfg.remote_wakeup, cfg.led_function_select, cfg.self_powered},
            4'b0101, "flags");
        $display("t_nostr done");
    endtask
    task automatic t_bad();
        img(8'h5a, 8'h07);
        item(5, 8'd18, 8'h30);
        strap <= 1'b1;
        run(1);
        chk({sa_hi, sa_lo}, 48'h0, "station");
        chk({cfg.fs_poll, cfg.hs_poll, cfg.lang_id}, 32'h0104_0409, "defaults");
        chk({cfg.lang_valid, cfg.item_present, cfg.remote_wakeup, cfg.self_powered},
            12'h002, "state");
        apb(1'b0, 12'h000);
        chk(rd, 32'h1, "status");
        ee_u.mem[0] = 8'ha5;
        reads = 0;
        dbytes = 0;
        pwdata <= 32'h1;
        apb(1'b1, 12'h004);
        idle();
        @(posedge pclk);
        wait_load(51);
        chk(dbytes, 18, "reload desc");
        chk({sa_hi, sa_lo}, 48'h3a39_383f_3e3d, "reload station");
        idle();
        $display("t_bad done");
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        t_full();
        t_nostr();
        t_bad();
        end_sim();
    end
    // Four loads take well under a thousand cycles; allow ten thousand
    initial begin
        #1000000;
        fails++;
        end_sim();
    end
endmodule
bind ecl_loader ecl_loader_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .ee_rd(ee_rd),
    .ee_ack(ee_ack), .desc(desc), .station_addr_wr(station_addr_wr),
    .usb_accept(usb_accept));
